// [lpsseq_bias_model.sv]
// Behavioural panel bias supply that watches for bias without live panel signals
module lpsseq_bias_model #(
	parameter int CHG_CYCLES = 16
) (
	input  wire logic sys_clk_i, // System clock
	input  wire logic rst_i,     // Async reset, active high
	input  wire logic bias_en_i, // Bias supply enable
	input  wire logic pclk_i,    // Panel pixel clock
	output logic      full_o,    // Bias fully charged
	output logic      empty_o,   // Bias fully discharged
	output logic      fault_o    // Bias seen while panel signals are dead
);
	timeunit 1ns;
	timeprecision 1ps;
	int level_q;
	int quiet_q;

	// Bias ramps one step a clock, so a discharge really takes time
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			level_q <= 0;
			quiet_q <= 0;
			fault_o <= 1'b0;
		end
		else
		begin
			if (bias_en_i && level_q < CHG_CYCLES)
				level_q <= level_q + 1;
			else if (!bias_en_i && level_q > 0)
				level_q <= level_q - 1;
			quiet_q <= pclk_i ? 0 : quiet_q + 1;
			// A long quiet pixel clock with charge left damages the panel
			if (level_q > 0 && quiet_q > 80)
				fault_o <= 1'b1;
		end
	end

	assign full_o  = (level_q == CHG_CYCLES);
	assign empty_o = (level_q == 0);
endmodule : lpsseq_bias_model

// [lpsseq_map.svh]
// Register map, field positions, reset values and timing counts of the power-save sequencer
// Behaviour
// - Enable bit 0 enters, clearing leaves power save
// - Power save stops refresh, LCD outputs low
// - Power save refuses memory; registers, LUT stay
// - Read-only bit 3 shows memory interface down
// - Memory-down status clears to zero on reset
// - Blank bit 7 at 1 shuts panel signals, 0 activates
// - Idle internal logic gated off automatically
`ifndef LPSSEQ_MAP_SVH
`define LPSSEQ_MAP_SVH

`define LPS_OFS_DISP_MODE  8'h70
`define LPS_OFS_PS_CFG     8'hA0
`define LPS_OFS_BIAS       8'hA4
`define LPS_OFS_IRQ_STAT   8'hA8
`define LPS_OFS_IRQ_MASK   8'hAC
`define LPS_OFS_LUT_IDX    8'hB0
`define LPS_OFS_LUT_DATA   8'hB4
`define LPS_MEM_WIN_BIT    12

`define LPS_PS_EN_BIT      0
`define LPS_MEM_PD_BIT     3
`define LPS_VND_BIT        7
`define LPS_BLANK_BIT      7

`define LPS_DISP_MODE_RST  8'h80
`define LPS_IRQ_PS_IN      0
`define LPS_IRQ_PS_OUT     1
`define LPS_IRQ_VND        2

`define LPS_MEM_PD_CYCLES  4
`define LPS_PCLK_DIV       2
`define LPS_H_TOTAL        16
`define LPS_H_ACTIVE       12
`define LPS_H_SYNC         2
`define LPS_V_TOTAL        8
`define LPS_V_ACTIVE       6

`endif

// [lpsseq_memgate.sv]
// Memory interface power-down sequencer
`include "lpsseq_map.svh"
module lpsseq_memgate #(
	parameter int PD_CYCLES = `LPS_MEM_PD_CYCLES
) (
	input  wire logic sys_clk_i,    // System clock
	input  wire logic rst_i,        // Async reset, active high
	input  wire logic ps_en_i,      // Power-save enable level
	output logic      mem_down_o,   // Memory interface powered down
	output logic      mem_active_o  // Memory interface usable
);
	lpsseq_pkg::lpsseq_mem_st_t state_q;
	lpsseq_pkg::lpsseq_mem_st_t state_d;
	logic [7:0]                 cnt_q;
	logic [7:0]                 cnt_d;
	wire                        cnt_done = (cnt_q == 8'(PD_CYCLES - 1));

	// Drain and wake both wait a fixed count so pending accesses settle
	always_comb
	begin
		state_d = state_q;
		cnt_d   = 8'h00;
		unique case (state_q)
			lpsseq_pkg::MEM_ACTIVE:
				if (ps_en_i)
					state_d = lpsseq_pkg::MEM_DRAIN;
			lpsseq_pkg::MEM_DRAIN:
				if (!ps_en_i)
					state_d = lpsseq_pkg::MEM_ACTIVE;
				else if (cnt_done)
					state_d = lpsseq_pkg::MEM_DOWN;
				else
					cnt_d = cnt_q + 8'h01;
			lpsseq_pkg::MEM_DOWN:
				if (!ps_en_i)
					state_d = lpsseq_pkg::MEM_WAKE;
			lpsseq_pkg::MEM_WAKE:
				if (cnt_done)
					state_d = lpsseq_pkg::MEM_ACTIVE;
				else
					cnt_d = cnt_q + 8'h01;
			default:
				state_d = lpsseq_pkg::MEM_ACTIVE;
		endcase
	end

	// State and status flops; down status clears and active status sets on reset
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_q      <= lpsseq_pkg::MEM_ACTIVE;
			cnt_q        <= 8'h00;
			mem_down_o   <= 1'b0;
			mem_active_o <= 1'b1;
		end
		else
		begin
			state_q      <= state_d;
			cnt_q        <= cnt_d;
			// Status stays 1 through wake, so a 0 means the interface is either usable or still draining
			mem_down_o   <= (state_d == lpsseq_pkg::MEM_DOWN) ||
				(state_d == lpsseq_pkg::MEM_WAKE);
			mem_active_o <= (state_d == lpsseq_pkg::MEM_ACTIVE);
		end
	end

	AST_PD_ONLY_IN_PS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$rose(mem_down_o) |-> $past(ps_en_i))
		else $error("memory went down without power save");
	AST_PD_BOUNDED: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ps_en_i && mem_active_o) [*1] ##1 ps_en_i [*1] |-> ##[0:8] (mem_down_o || !ps_en_i))
		else $error("memory did not power down in time");
endmodule : lpsseq_memgate

// [lpsseq_pkg.sv]
// Types shared by the power-save sequencer modules
package lpsseq_pkg;
	typedef enum logic [3:0] {
		MEM_ACTIVE = 4'h1,
		MEM_DRAIN  = 4'h2,
		MEM_DOWN   = 4'h4,
		MEM_WAKE   = 4'h8
	} lpsseq_mem_st_t;
endpackage : lpsseq_pkg

// [lpsseq_top.sv]
// Power-save and panel sequencing top with Wishbone slave, LUT, display memory and refresh
`include "lpsseq_map.svh"
module lpsseq_top #(
	parameter int LUT_DEPTH = 16,
	parameter int MEM_DEPTH = 64,
	parameter int PD_CYCLES = `LPS_MEM_PD_CYCLES
) (
	input  wire logic        sys_clk_i,             // System clock, 25 MHz
	input  wire logic        rst_i,                 // Async reset, active high
	input  wire logic        wb_cyc_i,              // Wishbone cycle
	input  wire logic        wb_stb_i,              // Wishbone strobe
	input  wire logic        wb_we_i,               // Wishbone write
	input  wire logic [15:0] wb_adr_i,              // Byte address
	input  wire logic [3:0]  wb_sel_i,              // Byte enables
	input  wire logic [31:0] wb_dat_i,              // Write data
	output logic      [31:0] wb_dat_o,              // Read data
	output logic             wb_ack_o,              // Acknowledge
	output logic             irq_o,                 // Level interrupt
	output logic             bias_control_output_o, // Panel bias supply enable
	output logic      [7:0]  lcd_data_o,            // Panel pixel data
	output logic             lcd_pclk_o,            // Panel pixel clock
	output logic             lcd_hsync_o,           // Line sync
	output logic             lcd_vsync_o,           // Frame sync
	output logic             lcd_den_o              // Data enable
);
	localparam int LW = $clog2(LUT_DEPTH);
	localparam int MW = $clog2(MEM_DEPTH);

	// Register match on the low address byte, outside the memory window
	function automatic logic hit(input logic [15:0] adr, input logic [7:0] ofs);
		hit = !adr[`LPS_MEM_WIN_BIT] && (adr[11:8] == 4'h0) && (adr[7:0] == ofs);
	endfunction : hit

	// Byte-lane merge for partial writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] m;
		m     = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		merge = (old & ~m) | (nw & m);
	endfunction : merge

	logic [7:0]  disp_mode_q;
	logic        ps_en_q;
	logic [2:0]  irq_stat_q;
	logic [2:0]  irq_mask_q;
	logic [7:0]  lut_idx_q;
	logic [23:0] lut_q [LUT_DEPTH];
	logic [31:0] vram_q [MEM_DEPTH];
	logic        mem_down;
	logic        mem_active;
	logic        mem_down_dly_q;
	logic        mem_active_dly_q;
	logic        vnd_dly_q;
	logic [7:0]  div_q;
	logic [7:0]  h_q;
	logic [7:0]  v_q;
	logic [MW-1:0] pix_q;

	lpsseq_memgate #(
		.PD_CYCLES (PD_CYCLES)
	) u_memgate (
		.sys_clk_i    (sys_clk_i),
		.rst_i        (rst_i),
		.ps_en_i      (ps_en_q),
		.mem_down_o   (mem_down),
		.mem_active_o (mem_active)
	);

	// Bus request decode; one wait state, ack is a single-cycle pulse
	wire req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wr       = req && wb_we_i;
	wire mem_sel  = wb_adr_i[`LPS_MEM_WIN_BIT];
	wire mem_ok   = !ps_en_q && mem_active;
	wire [MW-1:0] mem_idx = wb_adr_i[MW+1:2];
	wire [LW-1:0] lut_i   = lut_idx_q[LW-1:0];
	wire hit_disp = hit(wb_adr_i, `LPS_OFS_DISP_MODE);
	wire hit_ps   = hit(wb_adr_i, `LPS_OFS_PS_CFG);
	wire hit_bias = hit(wb_adr_i, `LPS_OFS_BIAS);
	wire hit_ist  = hit(wb_adr_i, `LPS_OFS_IRQ_STAT);
	wire hit_imk  = hit(wb_adr_i, `LPS_OFS_IRQ_MASK);
	wire hit_lidx = hit(wb_adr_i, `LPS_OFS_LUT_IDX);
	wire hit_ldat = hit(wb_adr_i, `LPS_OFS_LUT_DATA);
	wire wr_b0    = wr && wb_sel_i[0];
	wire blank    = disp_mode_q[`LPS_BLANK_BIT];

	// Refresh runs only when unblanked and out of power save; otherwise its clock enable stops
	wire run      = !blank && !ps_en_q && mem_active;
	wire pix_en   = run && (div_q == 8'(`LPS_PCLK_DIV - 1));
	wire h_end    = (h_q == 8'(`LPS_H_TOTAL - 1));
	wire v_end    = (v_q == 8'(`LPS_V_TOTAL - 1));
	wire vnd      = run && (v_q >= 8'(`LPS_V_ACTIVE));
	wire act      = (h_q < 8'(`LPS_H_ACTIVE)) && !vnd;
	wire [31:0] pix_word = vram_q[pix_q];

	// Status read-back: power-save config carries live status bits
	wire [7:0] ps_rd = {vnd, 3'h0, mem_down, 2'h0, ps_en_q};
	wire [2:0] ev    = {vnd && !vnd_dly_q,
		mem_active && !mem_active_dly_q,
		mem_down && !mem_down_dly_q};
	wire [31:0] rd_mux =
		mem_sel  ? (mem_ok ? vram_q[mem_idx] : 32'h0000_0000) :
		hit_disp ? {24'h000000, disp_mode_q} :
		hit_ps   ? {24'h000000, ps_rd} :
		hit_bias ? {31'h0000_0000, bias_control_output_o} :
		hit_ist  ? {29'h0000_0000, irq_stat_q} :
		hit_imk  ? {29'h0000_0000, irq_mask_q} :
		hit_lidx ? {24'h000000, lut_idx_q} :
		hit_ldat ? {8'h00, lut_q[lut_i]} : 32'h0000_0000;

	// Bus answer; unmapped addresses ack with zero
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= req;
			wb_dat_o <= (req && !wb_we_i) ? rd_mux : 32'h0000_0000;
		end
	end

	// Control registers; bias output changes only by its own write
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			disp_mode_q           <= `LPS_DISP_MODE_RST;
			ps_en_q               <= 1'b0;
			bias_control_output_o <= 1'b0;
			irq_mask_q            <= 3'h0;
			lut_idx_q             <= 8'h00;
		end
		else
		begin
			if (wr_b0 && hit_disp)
				disp_mode_q <= wb_dat_i[7:0];
			if (wr_b0 && hit_ps)
				ps_en_q <= wb_dat_i[`LPS_PS_EN_BIT];
			if (wr_b0 && hit_bias)
				bias_control_output_o <= wb_dat_i[0];
			if (wr_b0 && hit_imk)
				irq_mask_q <= wb_dat_i[2:0];
			if (wr_b0 && hit_lidx)
				lut_idx_q <= wb_dat_i[7:0];
		end
	end

	// Sticky events: a new event wins over a same-cycle write-one clear
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			irq_stat_q       <= 3'h0;
			irq_o            <= 1'b0;
			mem_down_dly_q   <= 1'b0;
			mem_active_dly_q <= 1'b1;
			vnd_dly_q        <= 1'b0;
		end
		else
		begin
			irq_stat_q       <= (irq_stat_q & ~((wr_b0 && hit_ist) ? wb_dat_i[2:0] : 3'h0)) | ev;
			irq_o            <= |(irq_stat_q & irq_mask_q);
			mem_down_dly_q   <= mem_down;
			mem_active_dly_q <= mem_active;
			vnd_dly_q        <= vnd;
		end
	end

	// LUT stays writable in power save; the host keeps off it while system clock is stopped
	wire [31:0] lut_wr = merge({8'h00, lut_q[lut_i]}, wb_dat_i, wb_sel_i);
	always_ff @(posedge sys_clk_i)
	begin
		if (wr && hit_ldat)
			lut_q[lut_i] <= lut_wr[23:0];
	end

	// Display memory; writes dropped while the interface is down
	always_ff @(posedge sys_clk_i)
	begin
		if (wr && mem_sel && mem_ok)
			vram_q[mem_idx] <= merge(vram_q[mem_idx], wb_dat_i, wb_sel_i);
	end

	// Timing counters clear and stay at zero while refresh is off, saving toggling power
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			div_q <= 8'h00;
			h_q   <= 8'h00;
			v_q   <= 8'h00;
			pix_q <= '0;
		end
		else if (!run)
		begin
			div_q <= 8'h00;
			h_q   <= 8'h00;
			v_q   <= 8'h00;
			pix_q <= '0;
		end
		else
		begin
			div_q <= pix_en ? 8'h00 : div_q + 8'h01;
			if (pix_en)
			begin
				h_q   <= h_end ? 8'h00 : h_q + 8'h01;
				v_q   <= h_end ? (v_end ? 8'h00 : v_q + 8'h01) : v_q;
				pix_q <= (h_end && v_end) ? '0 : (act ? pix_q + 1'b1 : pix_q);
			end
		end
	end

	// Panel outputs forced low whenever refresh is off
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			lcd_data_o  <= 8'h00;
			lcd_pclk_o  <= 1'b0;
			lcd_hsync_o <= 1'b0;
			lcd_vsync_o <= 1'b0;
			lcd_den_o   <= 1'b0;
		end
		else
		begin
			lcd_data_o  <= (run && act) ? lut_q[pix_word[LW-1:0]][7:0] : 8'h00;
			lcd_pclk_o  <= run && (div_q >= 8'(`LPS_PCLK_DIV / 2));
			lcd_hsync_o <= run && (h_q < 8'(`LPS_H_SYNC));
			lcd_vsync_o <= run && (v_q == 8'h00);
			lcd_den_o   <= run && act;
		end
	end

	AST_PS_OUTS_LOW: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ps_en_q && $past(ps_en_q) |->
		(lcd_data_o == 8'h00) && !lcd_pclk_o && !lcd_hsync_o && !lcd_vsync_o && !lcd_den_o)
		else $error("panel outputs active in power save");
	AST_BLANK_LOW: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		blank && $past(blank) |-> !lcd_den_o && !lcd_vsync_o && (lcd_data_o == 8'h00))
		else $error("panel outputs active while blanked");
	AST_MEM_REFUSED: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		req && !wb_we_i && mem_sel && ps_en_q |=> wb_ack_o && (wb_dat_o == 32'h0000_0000))
		else $error("display memory readable in power save");
	AST_LUT_OPEN: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wr && hit_ldat && (wb_sel_i == 4'hF) |=> (lut_q[$past(lut_i)] == $past(wb_dat_i[23:0])))
		else $error("LUT write lost");
	AST_PS_ENABLE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wr_b0 && hit_ps |=> ps_en_q == $past(wb_dat_i[0]))
		else $error("power-save enable not taken");
	AST_STATUS_BIT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		req && !wb_we_i && hit_ps |=> wb_dat_o[3] == $past(mem_down))
		else $error("memory status read wrong");
	AST_BIAS_HELD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$changed(bias_control_output_o) |-> $past(wr_b0 && hit_bias))
		else $error("bias output changed without its write");
	AST_ACK_PULSE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	AST_NO_RUN_IDLE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!run |=> (div_q == 8'h00) && (h_q == 8'h00))
		else $error("timing counters toggled while idle");

	COV_PS_DOWN: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(mem_down));
	COV_PS_WAKE: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(mem_active));
	COV_REFUSED: cover property (@(posedge sys_clk_i) disable iff (rst_i) wr && mem_sel && !mem_ok);
	COV_IRQ: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(irq_o));
endmodule : lpsseq_top

// [tb_lpsseq_top.sv]
// Self-checking bench for the power-save and panel sequencer
`include "lpsseq_map.svh"
`define CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin num_errors++; \
	$display("unexpected %0t %s: %0h vs %0h", $time, m, g, e); end end
module tb_lpsseq_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk_i = 1'b0;
	logic        rst_i     = 1'b1;
	logic        wb_cyc_i  = 1'b0;
	logic        wb_stb_i  = 1'b0;
	logic        wb_we_i   = 1'b0;
	logic [15:0] wb_adr_i  = 16'h0000;
	logic [3:0]  wb_sel_i  = 4'hF;
	logic [31:0] wb_dat_i  = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o, irq_o, bias_control_output_o;
	logic [7:0]  lcd_data_o;
	logic        lcd_pclk_o, lcd_hsync_o, lcd_vsync_o, lcd_den_o;
	logic        sup_full, sup_empty, sup_fault;
	int          num_errors  = 0;
	int          check_count = 0;

	always #20 sys_clk_i = ~sys_clk_i;

	lpsseq_top i_dut (.sys_clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .bias_control_output_o,
		.lcd_data_o, .lcd_pclk_o, .lcd_hsync_o, .lcd_vsync_o, .lcd_den_o);

	lpsseq_bias_model i_sup (.sys_clk_i, .rst_i, .bias_en_i(bias_control_output_o),
		.pclk_i(lcd_pclk_o), .full_o(sup_full), .empty_o(sup_empty), .fault_o(sup_fault));

	task automatic end_sim();
		if (num_errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim

	// One classic cycle; held until ack is sampled, then one idle cycle
	task automatic wb(input logic we, input logic [15:0] adr, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= wd;
		do
		begin
			@(posedge sys_clk_i);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 20);
		`CHK(wb_ack_o, 1'b1, "no ack")
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge sys_clk_i);
	endtask : wb

	task automatic wr(input logic [15:0] adr, input logic [31:0] wd);
		logic [31:0] rd;
		wb(1'b1, adr, wd, rd);
	endtask : wr

	task automatic rdchk(input logic [15:0] adr, input logic [31:0] exp, input logic [31:0] m);
		logic [31:0] rd;
		wb(1'b0, adr, 32'h0000_0000, rd);
		`CHK(rd & m, exp, "read")
	endtask : rdchk

	// Poll the memory-down status until it shows the wanted level
	task automatic poll(input logic v);
		logic [31:0] rd;
		int n;
		n = 0;
		do
		begin
			wb(1'b0, `LPS_OFS_PS_CFG, 32'h0000_0000, rd);
			n++;
		end
		while (rd[`LPS_MEM_PD_BIT] !== v && n < 40);
		`CHK(rd[`LPS_MEM_PD_BIT], v, "status")
	endtask : poll

	// Every panel output must stay low over the span
	task automatic lcd_low(input int cyc);
		repeat (cyc)
		begin
			@(posedge sys_clk_i);
			`CHK({lcd_data_o, lcd_pclk_o, lcd_hsync_o, lcd_vsync_o, lcd_den_o}, 12'h000, "lcd")
		end
	endtask : lcd_low

	// Bounded wait for a supply level (1: charged, 0: empty) or for a pixel clock
	task automatic wait_for(input int what);
		int n;
		n = 0;
		while ((what == 1 ? sup_full : what == 0 ? sup_empty : lcd_pclk_o) !== 1'b1 && n < 300)
		begin
			@(posedge sys_clk_i);
			n++;
		end
		`CHK(n < 300, 1'b1, "wait")
	endtask : wait_for

	task automatic t_reset();
		rdchk(`LPS_OFS_PS_CFG, 32'h0000_0000, 32'h0000_0009);
		rdchk(`LPS_OFS_DISP_MODE, 32'h0000_0080, 32'h0000_00FF);
		rdchk(16'h0040, 32'h0000_0000, 32'hFFFF_FFFF);
		lcd_low(20);
	endtask : t_reset

	task automatic t_panel_on();
		int seen;
		seen = 0;
		wr(`LPS_OFS_DISP_MODE, 32'h0000_0000);
		wait_for(2);
		wr(`LPS_OFS_BIAS, 32'h0000_0001);
		`CHK(bias_control_output_o, 1'b1, "bias")
		wait_for(1);
		// A full frame of refresh must show data enable and raise the nondisplay event
		repeat (300)
		begin
			@(posedge sys_clk_i);
			seen += lcd_den_o;
		end
		`CHK(seen > 0, 1'b1, "den")
		rdchk(`LPS_OFS_IRQ_STAT, 32'h0000_0004, 32'h0000_0004);
		wr(16'h1004, 32'hA5A5_5A5A);
		rdchk(16'h1004, 32'hA5A5_5A5A, 32'hFFFF_FFFF);
	endtask : t_panel_on

	// Clocks are never stopped here, so LUT access stays legal
	task automatic t_ps_enter();
		wr(`LPS_OFS_BIAS, 32'h0000_0000);
		wait_for(0);
		wr(`LPS_OFS_PS_CFG, 32'h0000_0001);
		poll(1'b1);
		lcd_low(300);
		wr(16'h1004, 32'h1234_5678);
		rdchk(16'h1004, 32'h0000_0000, 32'hFFFF_FFFF);
		wr(`LPS_OFS_LUT_IDX, 32'h0000_0003);
		wr(`LPS_OFS_LUT_DATA, 32'h00C3_96E1);
		rdchk(`LPS_OFS_LUT_DATA, 32'h00C3_96E1, 32'h00FF_FFFF);
		rdchk(`LPS_OFS_PS_CFG, 32'h0000_0009, 32'h0000_0009);
		`CHK(bias_control_output_o, 1'b0, "bias")
		rdchk(`LPS_OFS_IRQ_STAT, 32'h0000_0001, 32'h0000_0001);
		wr(`LPS_OFS_IRQ_MASK, 32'h0000_0001);
		@(posedge sys_clk_i);
		`CHK(irq_o, 1'b1, "irq on")
		wr(`LPS_OFS_IRQ_STAT, 32'h0000_0001);
		@(posedge sys_clk_i);
		`CHK(irq_o, 1'b0, "irq clear")
		wr(`LPS_OFS_IRQ_MASK, 32'h0000_0000);
	endtask : t_ps_enter

	task automatic t_ps_exit();
		wr(`LPS_OFS_PS_CFG, 32'h0000_0000);
		poll(1'b0);
		rdchk(16'h1004, 32'hA5A5_5A5A, 32'hFFFF_FFFF);
		rdchk(`LPS_OFS_IRQ_STAT, 32'h0000_0002, 32'h0000_0002);
		wait_for(2);
		wr(`LPS_OFS_BIAS, 32'h0000_0001);
		wait_for(1);
	endtask : t_ps_exit

	task automatic t_panel_off();
		wr(`LPS_OFS_BIAS, 32'h0000_0000);
		wait_for(0);
		wr(`LPS_OFS_DISP_MODE, 32'h0000_0080);
		@(posedge sys_clk_i);
		lcd_low(300);
		`CHK(sup_fault, 1'b0, "bias fault")
	endtask : t_panel_off

	initial
	begin
		repeat (8) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		t_reset();
		t_panel_on();
		t_ps_enter();
		t_ps_exit();
		t_panel_off();
		end_sim();
	end

	// Whole run needs a little over a thousand cycles; this cuts a hang short
	initial
	begin
		repeat (20000) @(posedge sys_clk_i);
		num_errors++;
		end_sim();
	end
endmodule : tb_lpsseq_top
